// ==== rcs_pkg.sv ====
// package for the reset cause and release timing block
package rcs_pkg;

  // timing clock and nominal delays
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned T_POR_US         = 10;
  localparam int unsigned T_STARTUP_REG_US = 20;
  localparam int unsigned T_STARTUP_OFF_MS = 64;
  localparam int unsigned T_RST_US         = 20;
  localparam int unsigned T_LOCK_US        = 20;
  localparam int unsigned T_CLOCK_FAIL_MONITOR_US        = 100;
  localparam int unsigned OST_PERIODS      = 1024;

  localparam int unsigned CNT_W = 24;
  localparam logic [23:0] POR_CYC     = 24'(T_POR_US * CLK_MHZ);
  localparam logic [23:0] START_CYC   = 24'(T_STARTUP_REG_US * CLK_MHZ);
  localparam logic [23:0] UNREG_CYC   = 24'(T_STARTUP_OFF_MS * 1000 * CLK_MHZ);
  localparam logic [23:0] RST_CYC     = 24'(T_RST_US * CLK_MHZ);
  localparam logic [23:0] CLOCK_FAIL_MONITOR_CYC    = 24'(T_CLOCK_FAIL_MONITOR_US * CLK_MHZ);
  localparam logic [11:0] LOCK_CYC    = 12'(T_LOCK_US * CLK_MHZ);
  localparam logic [9:0]  OST_LAST    = 10'(OST_PERIODS - 1);

  // apb byte offsets
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_CONFIG = 12'h004;
  localparam logic [11:0] ADDR_SEQ    = 12'h008;

  // reset_cause_status fields
  localparam int unsigned B_TRAP  = 15;
  localparam int unsigned B_ILL   = 14;
  localparam int unsigned B_VREG  = 8;
  localparam int unsigned B_PIN   = 7;
  localparam int unsigned B_SOFT  = 6;
  localparam int unsigned B_WDTEN = 5;
  localparam int unsigned B_WATCHDOG_TIMEOUT_FLAG  = 4;
  localparam int unsigned B_SLEEP = 3;
  localparam int unsigned B_IDLE  = 2;
  localparam int unsigned B_BOR   = 1;
  localparam int unsigned B_POR   = 0;
  localparam logic [15:0] STATUS_MASK  = 16'hC1FF;
  localparam logic [15:0] STATUS_RESET = 16'h0003;

  // config register: osc[6:4] fuse[3] mon[2] reg[1] clksw[0]
  localparam logic [6:0] CONFIG_RESET = 7'h0F;

  // oscillator source codes
  localparam logic [2:0] OSC_FRC    = 3'h0;
  localparam logic [2:0] OSC_FRCPLL = 3'h1;
  localparam logic [2:0] OSC_EC     = 3'h2;
  localparam logic [2:0] OSC_ECPLL  = 3'h3;
  localparam logic [2:0] OSC_XTHS   = 3'h4;
  localparam logic [2:0] OSC_XTPLL  = 3'h5;
  localparam logic [2:0] OSC_SECONDARY_OSC   = 3'h6;
  localparam logic [2:0] OSC_LOW_POWER_RC   = 3'h7;

  typedef enum logic [5:0] {
    ST_POR   = 6'h01,
    ST_START = 6'h02,
    ST_RST   = 6'h04,
    ST_MWAIT = 6'h08,
    ST_RUN   = 6'h10,
    ST_WAKE  = 6'h20
  } rcs_state_t;

  typedef struct packed {
    rcs_state_t  st;
    logic [23:0] cnt;
    logic [11:0] lock_cnt;
    logic        lock_done;
    logic [9:0]  ost_cnt;
    logic        ost_done;
    logic        full_rst;
    logic [2:0]  osc_sel;
    logic [15:0] status;
    logic [6:0]  cfg;
    logic        mon_active;
    logic        fail_sw;
    logic        trap;
    logic [31:0] prdata;
  } rcs_regs_t;

  function automatic logic is_pll(input logic [2:0] osc);
    return (osc == OSC_FRCPLL) || (osc == OSC_ECPLL) || (osc == OSC_XTPLL);
  endfunction

  function automatic logic is_xtal(input logic [2:0] osc);
    return (osc == OSC_XTHS) || (osc == OSC_XTPLL) || (osc == OSC_SECONDARY_OSC);
  endfunction

endpackage

// ==== rcs_reset_ctrl.sv ====
// reset cause register, clock choice and reset release sequencer
// Operation
// - trap conflict sets bit 15, por/bor clear
// - illegal op reset sets bit 14
// - bits 13 to 9 read zero
// - bit 8 keeps regulator on in sleep
// - pin reset sets bit 7, por only clears
// - soft reset sets bit 6, por/bor clear
// - bit 5 or fuse enables watchdog
// - watchdog timeout sets bit 4
// - sleep sets bit 3, idle bit 2
// - bor bit on bor/por, por bit on por
// - software writes flags, never causes reset
// - clock source by reset type when switching
// - no switching: always configured initial source
// - hold system reset until delays expire
// - release delay sum depends on reset type
// - startup delay by regulator, also on wake
// - ten-bit start-up timer counts 1024 periods
// - lock and start-up waits run in parallel
// - monitor start delay for pll/crystal full resets
// - no execution before clock released
// - dead clock at monitor start: rc plus trap
// - por clears flags except por and bor; others set own
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/100ps
module rcs_reset_ctrl #(
  parameter logic [23:0] UNREG_CYC = rcs_pkg::UNREG_CYC,
  parameter logic [23:0] CLOCK_FAIL_MONITOR_CYC  = rcs_pkg::CLOCK_FAIL_MONITOR_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_por_evt,
  input  wire logic        i_bor_evt,
  input  wire logic        i_pin_reset_evt,
  input  wire logic        i_soft_reset_evt,
  input  wire logic        i_wdt_timeout_evt,
  input  wire logic        i_trap_conflict_evt,
  input  wire logic        i_illegal_op_evt,
  input  wire logic        i_sleep_evt,
  input  wire logic        i_idle_evt,
  input  wire logic        i_wake_evt,
  input  wire logic [2:0]  i_current_osc_select,
  input  wire logic        i_osc_valid,
  input  wire logic        i_osc_tick,
  output logic             o_system_reset_signal,
  output logic             o_clock_released,
  output logic             o_run_enable,
  output logic [2:0]       o_osc_select,
  output logic             o_monitor_active,
  output logic             o_clock_fail_trap,
  output logic             o_watchdog_enable,
  output logic             o_regulator_sleep_keep
);

  localparam rcs_pkg::rcs_regs_t REGS_RESET = '{
    st:         rcs_pkg::ST_POR,
    cnt:        rcs_pkg::POR_CYC - 24'h0001,
    lock_cnt:   rcs_pkg::LOCK_CYC - 12'h001,
    lock_done:  !rcs_pkg::is_pll(rcs_pkg::CONFIG_RESET[6:4]),
    ost_cnt:    10'h000,
    ost_done:   !rcs_pkg::is_xtal(rcs_pkg::CONFIG_RESET[6:4]),
    full_rst:   1'b1,
    osc_sel:    rcs_pkg::CONFIG_RESET[6:4],
    status:     rcs_pkg::STATUS_RESET,
    cfg:        rcs_pkg::CONFIG_RESET,
    mon_active: 1'b0,
    fail_sw:    1'b0,
    trap:       1'b0,
    prdata:     32'h0000_0000
  };

  rcs_pkg::rcs_regs_t r_q;
  rcs_pkg::rcs_regs_t r_d;

  logic        setup;
  logic        access;
  logic        mapped;
  logic        wr;
  logic        por;
  logic        bor;
  logic        other;
  logic        clk_ready;
  logic        system_reset_signal;
  logic        mon_start;
  logic [2:0]  new_osc;
  logic [15:0] wmerge;
  logic [31:0] rdata;

  always_comb
  begin
    setup  = i_psel && !i_penable;
    access = i_psel && i_penable;
    mapped = (i_paddr == rcs_pkg::ADDR_STATUS) ||
             (i_paddr == rcs_pkg::ADDR_CONFIG) ||
             (i_paddr == rcs_pkg::ADDR_SEQ);
    wr     = access && i_pwrite && mapped;
    por    = i_por_evt;
    bor    = i_bor_evt && !por;
    other  = !por && !bor && (i_pin_reset_evt || i_soft_reset_evt ||
             i_wdt_timeout_evt || i_trap_conflict_evt || i_illegal_op_evt);
    clk_ready = r_q.lock_done && r_q.ost_done;
    system_reset_signal = (r_q.st == rcs_pkg::ST_POR) || (r_q.st == rcs_pkg::ST_START) ||
             (r_q.st == rcs_pkg::ST_RST);
    wmerge[15:8] = i_pstrb[1] ? i_pwdata[15:8] : r_q.status[15:8];
    wmerge[7:0]  = i_pstrb[0] ? i_pwdata[7:0] : r_q.status[7:0];
    // clock switching keeps the running source on warm resets
    if (r_q.cfg[0] && !por && !bor)
    begin
      new_osc = i_current_osc_select;
    end
    else
    begin
      new_osc = r_q.cfg[6:4];
    end
    rdata = 32'h0000_0000;
    case (i_paddr)
      rcs_pkg::ADDR_STATUS: rdata[15:0] = r_q.status & rcs_pkg::STATUS_MASK;
      rcs_pkg::ADDR_CONFIG: rdata[6:0] = r_q.cfg;
      rcs_pkg::ADDR_SEQ:
      begin
        rdata[0]   = system_reset_signal;
        rdata[1]   = clk_ready;
        rdata[2]   = o_run_enable;
        rdata[3]   = r_q.mon_active;
        rdata[4]   = r_q.fail_sw;
        rdata[7:5] = r_q.osc_sel;
        rdata[13:8] = r_q.st;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    r_d       = r_q;
    r_d.trap  = 1'b0;
    mon_start = 1'b0;
    if (setup)
    begin
      r_d.prdata = rdata;
    end

    // status flags: write, then hardware clears, then sets win
    if (wr && (i_paddr == rcs_pkg::ADDR_STATUS))
    begin
      r_d.status = wmerge & rcs_pkg::STATUS_MASK;
    end
    if (wr && (i_paddr == rcs_pkg::ADDR_CONFIG))
    begin
      r_d.cfg = i_pwdata[6:0];
    end
    if (por)
    begin
      r_d.status = rcs_pkg::STATUS_RESET;
    end
    if (bor)
    begin
      r_d.status[rcs_pkg::B_TRAP]  = 1'b0;
      r_d.status[rcs_pkg::B_ILL]   = 1'b0;
      r_d.status[rcs_pkg::B_SOFT]  = 1'b0;
      r_d.status[rcs_pkg::B_WATCHDOG_TIMEOUT_FLAG]  = 1'b0;
      r_d.status[rcs_pkg::B_SLEEP] = 1'b0;
      r_d.status[rcs_pkg::B_IDLE]  = 1'b0;
      r_d.status[rcs_pkg::B_BOR]   = 1'b1;
    end
    if (i_sleep_evt || i_idle_evt)
    begin
      r_d.status[rcs_pkg::B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
    end
    if (!por)
    begin
      if (i_trap_conflict_evt)
      begin
        r_d.status[rcs_pkg::B_TRAP] = 1'b1;
      end
      if (i_illegal_op_evt)
      begin
        r_d.status[rcs_pkg::B_ILL] = 1'b1;
      end
      if (i_pin_reset_evt)
      begin
        r_d.status[rcs_pkg::B_PIN] = 1'b1;
      end
      if (i_soft_reset_evt)
      begin
        r_d.status[rcs_pkg::B_SOFT] = 1'b1;
      end
      if (i_wdt_timeout_evt)
      begin
        r_d.status[rcs_pkg::B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
      end
      if (i_sleep_evt)
      begin
        r_d.status[rcs_pkg::B_SLEEP] = 1'b1;
      end
      if (i_idle_evt)
      begin
        r_d.status[rcs_pkg::B_IDLE] = 1'b1;
      end
    end

    // oscillator waits run beside the reset delay
    if (!r_q.lock_done)
    begin
      if (r_q.lock_cnt == 12'h000)
      begin
        r_d.lock_done = 1'b1;
      end
      else
      begin
        r_d.lock_cnt = r_q.lock_cnt - 12'h001;
      end
    end
    if (!r_q.ost_done && i_osc_tick && i_osc_valid)
    begin
      r_d.ost_cnt = r_q.ost_cnt + 10'h001;
      if (r_q.ost_cnt == rcs_pkg::OST_LAST)
      begin
        r_d.ost_done = 1'b1;
      end
    end

    // release sequencer
    case (r_q.st)
      rcs_pkg::ST_POR:
      begin
        r_d.cnt = r_q.cnt - 24'h0001;
        if (r_q.cnt == 24'h0000)
        begin
          r_d.st  = rcs_pkg::ST_START;
          r_d.cnt = (r_q.cfg[1] ? rcs_pkg::START_CYC : UNREG_CYC) - 24'h0001;
        end
      end
      rcs_pkg::ST_START:
      begin
        r_d.cnt = r_q.cnt - 24'h0001;
        if (r_q.cnt == 24'h0000)
        begin
          r_d.st  = rcs_pkg::ST_RST;
          r_d.cnt = rcs_pkg::RST_CYC - 24'h0001;
        end
      end
      rcs_pkg::ST_RST:
      begin
        r_d.cnt = r_q.cnt - 24'h0001;
        if (r_q.cnt == 24'h0000)
        begin
          if (r_q.full_rst && (rcs_pkg::is_pll(r_q.osc_sel) ||
              rcs_pkg::is_xtal(r_q.osc_sel)))
          begin
            r_d.st  = rcs_pkg::ST_MWAIT;
            r_d.cnt = CLOCK_FAIL_MONITOR_CYC - 24'h0001;
          end
          else
          begin
            r_d.st    = rcs_pkg::ST_RUN;
            mon_start = 1'b1;
          end
        end
      end
      rcs_pkg::ST_MWAIT:
      begin
        r_d.cnt = r_q.cnt - 24'h0001;
        if (r_q.cnt == 24'h0000)
        begin
          r_d.st    = rcs_pkg::ST_RUN;
          mon_start = 1'b1;
        end
      end
      rcs_pkg::ST_RUN:
      begin
        // with the regulator off, waking costs no start-up delay
        if (i_wake_evt && r_q.cfg[1])
        begin
          r_d.st  = rcs_pkg::ST_WAKE;
          r_d.cnt = rcs_pkg::START_CYC - 24'h0001;
        end
      end
      rcs_pkg::ST_WAKE:
      begin
        r_d.cnt = r_q.cnt - 24'h0001;
        if (r_q.cnt == 24'h0000)
        begin
          r_d.st = rcs_pkg::ST_RUN;
        end
      end
      default:
      begin
        r_d.st  = rcs_pkg::ST_POR;
        r_d.cnt = rcs_pkg::POR_CYC - 24'h0001;
      end
    endcase

    // a dead clock at the start of monitoring falls back to rc
    if (mon_start && r_q.cfg[2])
    begin
      r_d.mon_active = 1'b1;
      if (!i_osc_valid)
      begin
        r_d.osc_sel = rcs_pkg::OSC_FRC;
        r_d.fail_sw = 1'b1;
        r_d.trap    = 1'b1;
      end
    end

    // any reset source restarts the sequence; status writes never do
    if (por || bor || other)
    begin
      r_d.full_rst   = por || bor;
      r_d.osc_sel    = new_osc;
      r_d.mon_active = 1'b0;
      r_d.fail_sw    = 1'b0;
      // a reset in the monitor start cycle cancels the trap, the source is replaced
      r_d.trap       = 1'b0;
      r_d.lock_cnt   = rcs_pkg::LOCK_CYC - 12'h001;
      r_d.lock_done  = !((por || bor) && rcs_pkg::is_pll(new_osc));
      r_d.ost_cnt    = 10'h000;
      r_d.ost_done   = !((por || bor) && rcs_pkg::is_xtal(new_osc));
      if (por)
      begin
        r_d.st  = rcs_pkg::ST_POR;
        r_d.cnt = rcs_pkg::POR_CYC - 24'h0001;
      end
      else if (bor)
      begin
        r_d.st  = rcs_pkg::ST_START;
        r_d.cnt = (r_q.cfg[1] ? rcs_pkg::START_CYC : UNREG_CYC) - 24'h0001;
      end
      else
      begin
        r_d.st  = rcs_pkg::ST_RST;
        r_d.cnt = rcs_pkg::RST_CYC - 24'h0001;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      r_q <= REGS_RESET;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // zero-wait slave: every access completes in its first access cycle
  assign o_pready  = 1'b1;
  assign o_pslverr = access && !mapped;
  assign o_prdata  = r_q.prdata;

  assign o_system_reset_signal = system_reset_signal;
  assign o_clock_released      = clk_ready;
  assign o_run_enable = !system_reset_signal && clk_ready && (r_q.st != rcs_pkg::ST_WAKE);
  assign o_osc_select          = r_q.osc_sel;
  assign o_monitor_active      = r_q.mon_active;
  assign o_clock_fail_trap     = r_q.trap;
  // an unprogrammed fuse leaves the watchdog running regardless
  assign o_watchdog_enable = r_q.cfg[3] || r_q.status[rcs_pkg::B_WDTEN];
  assign o_regulator_sleep_keep = r_q.status[rcs_pkg::B_VREG];

endmodule

// ==== rcs_chk.sv ====
// port assertions for the reset controller
`timescale 1ns/100ps
module rcs_chk (
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0]  i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic        i_por_evt,
  input wire logic        i_bor_evt,
  input wire logic        i_pin_reset_evt,
  input wire logic        i_soft_reset_evt,
  input wire logic        i_wdt_timeout_evt,
  input wire logic        i_trap_conflict_evt,
  input wire logic        i_illegal_op_evt,
  input wire logic        o_system_reset_signal,
  input wire logic        o_clock_released,
  input wire logic        o_run_enable,
  input wire logic [2:0]  o_osc_select,
  input wire logic        o_clock_fail_trap,
  input wire logic        o_watchdog_enable,
  input wire logic        o_regulator_sleep_keep
);
  logic        warm;
  logic        full;
  logic        wr;
  logic        warm_q;
  logic [23:0] cnt_q;
  assign warm = i_pin_reset_evt | i_soft_reset_evt | i_wdt_timeout_evt
              | i_trap_conflict_evt | i_illegal_op_evt;
  assign full = i_por_evt | i_bor_evt;
  assign wr   = i_psel & i_penable & i_pwrite & (i_paddr == 12'h000);
  // counts high cycles of the last reset; any event restarts it
  always_ff @(posedge i_clk_sys or posedge i_reset)
    if (i_reset)
    begin
      warm_q <= 1'b0;
      cnt_q  <= 24'h00_0000;
    end
    else
    begin
      warm_q <= full ? 1'b0 : (warm | warm_q);
      cnt_q  <= (warm | full | !o_system_reset_signal) ? 24'h00_0000 : cnt_q + 24'h00_0001;
    end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  a_evt_raise: assert property ((warm | full) |=> o_system_reset_signal)
    else $error("reset not raised by event");
  a_warm_len: assert property ($fell(o_system_reset_signal) && warm_q |->
    cnt_q >= rcs_pkg::RST_CYC - 2 && cnt_q <= rcs_pkg::RST_CYC + 2)
    else $error("warm reset length wrong");
  a_sw_no_rst: assert property (wr && !(warm | full) && !o_system_reset_signal
    |=> !o_system_reset_signal)
    else $error("write caused reset");
  a_run_gate: assert property (o_run_enable |-> o_clock_released && !o_system_reset_signal)
    else $error("run without clock");
  a_fail_rc: assert property (o_clock_fail_trap |-> o_osc_select == 3'h0
    ##1 !o_clock_fail_trap)
    else $error("fail trap wrong");
  a_resv_zero: assert property (i_psel && !i_penable && !i_pwrite && i_paddr == 12'h000
    |=> o_prdata[31:16] == 16'h0000 && o_prdata[13:9] == 5'h00)
    else $error("reserved bits not zero");
  a_wdt_on: assert property (wr && i_pstrb[0] && i_pwdata[5] && !i_por_evt
    |=> o_watchdog_enable)
    else $error("watchdog not enabled");
  a_reg_keep: assert property (wr && i_pstrb[1] && !i_por_evt
    |=> o_regulator_sleep_keep == $past(i_pwdata[8]))
    else $error("regulator keep wrong");
endmodule
bind rcs_reset_ctrl rcs_chk u_chk (.*);

// ==== rcs_osc_model.sv ====
// oscillator model on the far side of the reset controller
`timescale 1ns/100ps
module rcs_osc_model #(
  parameter int TICK = 3
) (
  input  wire logic i_clk_sys,
  input  wire logic i_osc_on,
  output logic      o_osc_tick,
  output logic      o_osc_valid
);
  int div_q = 0;
  // runs free; a dead source gives neither ticks nor valid
  always @(posedge i_clk_sys)
  begin
    div_q       <= (div_q >= TICK - 1) ? 0 : div_q + 1;
    o_osc_tick  <= i_osc_on && div_q == 0;
    o_osc_valid <= i_osc_on;
  end
endmodule

// ==== tb_reset_cause_and_release_timing.sv ====
// self-checking bench for the reset controller
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_reset_cause_and_release_timing;
  logic        i_clk_sys = 1'b0;
  logic        i_reset   = 1'b1;
  logic        psel      = 1'b0;
  logic        pen       = 1'b0;
  logic        pwr       = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic [3:0]  pstrb     = 4'hF;
  logic [9:0]  ev        = 10'h000;
  logic [2:0]  cur_osc   = 3'h2;
  logic        osc_on    = 1'b1;
  logic [31:0] rd;
  logic [31:0] prdata;
  logic [2:0]  osc_sel;
  logic        err, pready, pslverr, tick, valid, seen;
  logic        system_reset_signal, clk_rel, run, mon, trap, wdt_en, reg_keep;
  int          fails = 0;
  int          compares = 0;
  int          n;
  always #2.5 i_clk_sys = ~i_clk_sys;
  rcs_osc_model osc (.i_clk_sys(i_clk_sys), .i_osc_on(osc_on), .o_osc_tick(tick),
    .o_osc_valid(valid));
  rcs_reset_ctrl #(.UNREG_CYC(24'h00_0032), .CLOCK_FAIL_MONITOR_CYC(24'h00_0014)) dut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_por_evt(ev[0]), .i_bor_evt(ev[1]), .i_pin_reset_evt(ev[2]),
    .i_soft_reset_evt(ev[3]), .i_wdt_timeout_evt(ev[4]), .i_trap_conflict_evt(ev[5]),
    .i_illegal_op_evt(ev[6]), .i_sleep_evt(ev[7]), .i_idle_evt(ev[8]),
    .i_wake_evt(ev[9]), .i_current_osc_select(cur_osc), .i_osc_valid(valid),
    .i_osc_tick(tick), .o_system_reset_signal(system_reset_signal), .o_clock_released(clk_rel),
    .o_run_enable(run), .o_osc_select(osc_sel), .o_monitor_active(mon),
    .o_clock_fail_trap(trap), .o_watchdog_enable(wdt_en),
    .o_regulator_sleep_keep(reg_keep));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
    @(posedge i_clk_sys);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge i_clk_sys);
    pen <= 1'b1;
    // no wait count assumed; the watchdog ends a stuck access
    do
    begin
      @(posedge i_clk_sys);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic pulse(input int i);
    @(posedge i_clk_sys);
    ev[i] <= 1'b1;
    @(posedge i_clk_sys);
    ev[i] <= 1'b0;
  endtask
  // cycles until reset (w=0) or the run hold (w=1) ends
  task automatic span(input logic w, input int exp);
    n = 0;
    do
    begin
      @(posedge i_clk_sys);
      n++;
    end
    while ((w ? !run : system_reset_signal) === 1'b1 && n < 200000);
    `CHK(n >= exp - 2 && n <= exp + 2, 1'b1)
  endtask
  task automatic t_power_on;
    span(0, rcs_pkg::POR_CYC + rcs_pkg::START_CYC + rcs_pkg::RST_CYC);
    apb(0, 12'h000, 0);
    `CHK(rd, 32'h0000_0003)
    apb(0, 12'h010, 0);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
  endtask
  task automatic t_sw_write;
    apb(1, 12'h000, 32'hFFFF_FFFF);
    apb(0, 12'h000, 0);
    `CHK(rd, 32'h0000_C1FF)
    `CHK({system_reset_signal, wdt_en, reg_keep}, 3'b011)
    apb(1, 12'h000, 0);
    apb(1, 12'h004, 32'h0000_0007);
    apb(0, 12'h000, 0);
    `CHK({rd[15:0], wdt_en, reg_keep}, 18'h0_0000)
    apb(1, 12'h000, 32'h0000_FFFF, 4'h1);
    apb(0, 12'h000, 0);
    `CHK({rd, wdt_en}, {32'h0000_00FF, 1'b1})
    apb(1, 12'h004, 32'h0000_000F);
  endtask
  task automatic t_warm;
    int b[5];
    b = '{7, 6, 4, 15, 14};
    for (int i = 0; i < 5; i++)
    begin
      apb(1, 12'h000, 0);
      pulse(i + 2);
      span(0, rcs_pkg::RST_CYC);
      apb(0, 12'h000, 0);
      `CHK(rd, 32'h0000_0001 << b[i])
      `CHK({osc_sel, run}, {cur_osc, 1'b1})
    end
  endtask
  task automatic t_power_save;
    apb(1, 12'h000, 32'h0000_0010);
    pulse(7);
    apb(0, 12'h000, 0);
    `CHK(rd, 32'h0000_0008)
    apb(1, 12'h000, 32'h0000_0010);
    pulse(8);
    apb(0, 12'h000, 0);
    `CHK(rd, 32'h0000_0004)
  endtask
  task automatic t_bor;
    apb(1, 12'h000, 32'h0000_FFFF);
    apb(1, 12'h004, 32'h0000_005F);
    pulse(1);
    span(0, rcs_pkg::START_CYC + rcs_pkg::RST_CYC);
    `CHK({clk_rel, mon, osc_sel}, {2'b10, 3'h5})
    repeat (23) @(posedge i_clk_sys);
    `CHK({mon, trap}, 2'b10)
    apb(0, 12'h000, 0);
    `CHK(rd, 32'h0000_01A3)
  endtask
  task automatic t_unreg;
    apb(1, 12'h004, 32'h0000_000D);
    pulse(1);
    span(0, 50 + rcs_pkg::RST_CYC);
    `CHK(osc_sel, 3'h0)
    apb(1, 12'h004, 32'h0000_004C);
    pulse(2);
    span(0, rcs_pkg::RST_CYC);
    `CHK(osc_sel, 3'h4)
    apb(1, 12'h004, 32'h0000_000F);
    pulse(9);
    span(1, rcs_pkg::START_CYC);
  endtask
  task automatic t_fail;
    apb(1, 12'h004, 32'h0000_001F);
    apb(1, 12'h000, 32'h0000_FFFF);
    osc_on <= 1'b0;
    pulse(0);
    span(0, rcs_pkg::POR_CYC + rcs_pkg::START_CYC + rcs_pkg::RST_CYC);
    seen = 1'b0;
    repeat (40)
    begin
      @(posedge i_clk_sys);
      seen = seen | trap;
    end
    `CHK({seen, osc_sel}, {1'b1, 3'h0})
    apb(0, 12'h000, 0);
    `CHK(rd, 32'h0000_0003)
    osc_on <= 1'b1;
  endtask
  task automatic print_verdict;
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    t_power_on;
    t_sw_write;
    t_warm;
    t_power_save;
    t_bor;
    t_unreg;
    t_fail;
    print_verdict;
  end
  // whole run is near 60k cycles
  initial
  begin
    #450_000;
    fails++;
    print_verdict;
  end
endmodule
